// ===== design/capture_compare_mode_control.sv
`timescale 1ns/1ns
// Function
// - control bits 7-6 read zero, writes ignored
// - PWM modes: bits 5-4 are duty LSBs
// - mode 0000 disables and resets unit
// - capture on fall, rise, 4th, 16th rise
// - mode 1000 drives output high on match
// - mode 1001 drives output low on match
// - mode 1010 flag only, pin unchanged
// - mode 1011 flag, timer reset, conversion start
// - capture copies 16-bit timer value
// - flag set by hardware, cleared by software
// - newer capture overwrites unread value
// - edge detector watches pin regardless of direction
// - prescaler cleared outside capture modes
// - prescale switch keeps count intact
module capture_compare_mode_control #(
  parameter int TIMER_WIDTH = 16
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [TIMER_WIDTH-1:0] freeRunningTimer,
  input  wire logic        unitPin,
  output logic             unitOut,
  output logic             timerReset,
  output logic             conversionStart,
  output logic [9:0]       pwmDuty,
  output logic             pwmMode,
  output logic             irq
);
  // only a 16-bit timer fits the capture and compare registers
  if (TIMER_WIDTH != 16) begin : g_width_check
    $error("TIMER_WIDTH must be 16");
  end

  typedef struct packed {
    logic [ccm_pkg::CTRL_WIDTH-1:0]  control;
    logic [15:0]                     captureValue;
    logic [15:0]                     compareValue;
    logic [7:0]                      dutyHigh;
    logic [3:0]                      prescaleCount;
    logic [ccm_pkg::IRQ_BITS-1:0]    irqStatus;
    logic [ccm_pkg::IRQ_BITS-1:0]    irqEnable;
    logic                            adcEnable;
    logic                            unitOut;
    logic                            timerReset;
    logic                            conversionStart;
    logic                            ack;
    logic [31:0]                     rdata;
    logic                            irq;
    logic                            pwmMode;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic [1:0] rstSync;
  logic   rstN;
  logic   pinRise;
  logic   pinFall;
  logic   access;
  logic   wr;
  logic [3:0] mode;
  logic   capMode;
  logic   capEvent;
  logic   match;
  logic [31:0] rdMux;

  // internal reset released through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  // asserts at once, leaves in step with clk
  assign rstN = rstSync[1];

  edge_sync u_pin (
    .clk   (clk),
    .rstN  (rstN),
    .level (unitPin),
    .rise  (pinRise),
    .fall  (pinFall)
  );

  // decoded mode; ack blocks a second take of a held strobe
  assign mode    = cur.control[ccm_pkg::MODE_LSB +: 4];
  assign capMode = mode[3:2] == 2'b01;
  assign access  = wb_cyc_i & wb_stb_i & ~cur.ack;
  assign wr      = access & wb_we_i & wb_sel_i[0];
  assign match   = freeRunningTimer == cur.compareValue;

  always_comb begin
    capEvent = 1'b0;
    unique case (mode)
      ccm_pkg::MODE_CAP_FALL:   capEvent = pinFall;
      ccm_pkg::MODE_CAP_RISE:   capEvent = pinRise;
      ccm_pkg::MODE_CAP_RISE4:  capEvent = pinRise &&
                                           cur.prescaleCount[1:0] == ccm_pkg::PRESCALE_4[1:0];
      ccm_pkg::MODE_CAP_RISE16: capEvent = pinRise && cur.prescaleCount == ccm_pkg::PRESCALE_16;
      default:                  capEvent = 1'b0;
    endcase
  end

  // read data multiplexer
  always_comb begin
    rdMux = 32'h00000000;
    unique case (wb_adr_i)
      ccm_pkg::ADDR_CONTROL:  rdMux = {26'h0, cur.control};
      ccm_pkg::ADDR_CAPTURE:  rdMux = {16'h0000, cur.captureValue};
      ccm_pkg::ADDR_COMPARE:  rdMux = {16'h0000, cur.compareValue};
      ccm_pkg::ADDR_DUTY:     rdMux = {24'h000000, cur.dutyHigh};
      ccm_pkg::ADDR_IRQ_STAT: rdMux = {30'h0, cur.irqStatus};
      ccm_pkg::ADDR_IRQ_EN:   rdMux = {30'h0, cur.irqEnable};
      ccm_pkg::ADDR_ADC_EN:   rdMux = {31'h0, cur.adcEnable};
      default:                rdMux = 32'h00000000;
    endcase
  end

  // next-state logic
  always_comb begin
    next_cur                 = cur;
    next_cur.ack             = access;
    next_cur.rdata           = access ? rdMux : cur.rdata;
    next_cur.timerReset      = 1'b0;
    next_cur.conversionStart = 1'b0;

    // register writes
    if (wr) begin
      unique case (wb_adr_i)
        ccm_pkg::ADDR_CONTROL: next_cur.control = wb_dat_i[ccm_pkg::CTRL_WIDTH-1:0];
        ccm_pkg::ADDR_DUTY:    next_cur.dutyHigh = wb_dat_i[7:0];
        ccm_pkg::ADDR_IRQ_EN:  next_cur.irqEnable = wb_dat_i[ccm_pkg::IRQ_BITS-1:0];
        ccm_pkg::ADDR_ADC_EN:  next_cur.adcEnable = wb_dat_i[0];
        ccm_pkg::ADDR_IRQ_CLR: next_cur.irqStatus = cur.irqStatus &
                                                    ~wb_dat_i[ccm_pkg::IRQ_BITS-1:0];
        default: ;
      endcase
    end
    if (access && wb_we_i && wb_adr_i == ccm_pkg::ADDR_COMPARE) begin
      if (wb_sel_i[0]) next_cur.compareValue[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) next_cur.compareValue[15:8] = wb_dat_i[15:8];
    end

    if (!capMode) begin
      next_cur.prescaleCount = 4'h0;
    end else if (pinRise && mode[1]) begin
      next_cur.prescaleCount = cur.prescaleCount + 4'h1;
    end

    if (capEvent) begin
      next_cur.captureValue = freeRunningTimer;
    end

    if (capEvent) begin
      next_cur.irqStatus[ccm_pkg::IRQ_CAPTURE] = 1'b1;
    end

    // compare actions
    if (match && mode[3:2] == 2'b10) begin
      next_cur.irqStatus[ccm_pkg::IRQ_COMPARE] = 1'b1;
      unique case (mode)
        ccm_pkg::MODE_CMP_SET: next_cur.unitOut = 1'b1;
        ccm_pkg::MODE_CMP_CLR: next_cur.unitOut = 1'b0;
        ccm_pkg::MODE_CMP_SOFT: next_cur.unitOut = cur.unitOut;
        ccm_pkg::MODE_CMP_SPEC: begin
          next_cur.timerReset      = 1'b1;
          next_cur.conversionStart = cur.adcEnable;
        end
        default: ;
      endcase
    end

    if (mode == ccm_pkg::MODE_OFF) begin
      next_cur.unitOut       = 1'b0;
      next_cur.prescaleCount = 4'h0;
    end

    next_cur.irq = |(next_cur.irqStatus & next_cur.irqEnable);
    // PWM flag from the new mode
    next_cur.pwmMode = &next_cur.control[ccm_pkg::MODE_LSB + 2 +: 2];
  end

  // main state register
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cur.control         <= ccm_pkg::CTRL_RESET;
      cur.captureValue    <= 16'h0000;
      cur.compareValue    <= 16'h0000;
      cur.dutyHigh        <= 8'h00;
      cur.prescaleCount   <= 4'h0;
      cur.irqStatus       <= '0;
      cur.irqEnable       <= '0;
      cur.adcEnable       <= 1'b0;
      cur.unitOut         <= 1'b0;
      cur.timerReset      <= 1'b0;
      cur.conversionStart <= 1'b0;
      cur.ack             <= 1'b0;
      cur.rdata           <= 32'h00000000;
      cur.irq             <= 1'b0;
      cur.pwmMode         <= 1'b0;
    end else begin
      cur.control         <= next_cur.control;
      cur.captureValue    <= next_cur.captureValue;
      cur.compareValue    <= next_cur.compareValue;
      cur.dutyHigh        <= next_cur.dutyHigh;
      cur.prescaleCount   <= next_cur.prescaleCount;
      cur.irqStatus       <= next_cur.irqStatus;
      cur.irqEnable       <= next_cur.irqEnable;
      cur.adcEnable       <= next_cur.adcEnable;
      cur.unitOut         <= next_cur.unitOut;
      cur.timerReset      <= next_cur.timerReset;
      cur.conversionStart <= next_cur.conversionStart;
      cur.ack             <= next_cur.ack;
      cur.rdata           <= next_cur.rdata;
      cur.irq             <= next_cur.irq;
      cur.pwmMode         <= next_cur.pwmMode;
    end
  end

  // outputs
  assign wb_dat_o        = cur.rdata;
  assign wb_ack_o        = cur.ack;
  assign unitOut         = cur.unitOut;
  assign timerReset      = cur.timerReset;
  assign conversionStart = cur.conversionStart;
  assign irq             = cur.irq;
  assign pwmMode         = cur.pwmMode;
  assign pwmDuty         = {cur.dutyHigh, cur.control[ccm_pkg::DUTY_LSB_POS +: 2]};

  // assertions
  a_capture_latch: assert property (@(posedge clk) disable iff (!rstN)
    capEvent |=> cur.captureValue == $past(freeRunningTimer))
    else $error("capture value not latched");
  a_flag_sticky: assert property (@(posedge clk) disable iff (!rstN)
    cur.irqStatus[0] && !(wr && wb_adr_i == ccm_pkg::ADDR_IRQ_CLR && wb_dat_i[0])
    |=> cur.irqStatus[0])
    else $error("capture flag lost");
  a_flag_set: assert property (@(posedge clk) disable iff (!rstN)
    capEvent |=> cur.irqStatus[0])
    else $error("capture flag not set");
  a_prescale_clear: assert property (@(posedge clk) disable iff (!rstN)
    !capMode |=> cur.prescaleCount == 4'h0)
    else $error("prescaler not cleared");
  a_top_bits: assert property (@(posedge clk) disable iff (!rstN)
    cur.ack && $past(wb_adr_i) == ccm_pkg::ADDR_CONTROL && !$past(wb_we_i)
    |-> wb_dat_o[7:6] == 2'b00)
    else $error("control top bits nonzero");
  a_cmp_high: assert property (@(posedge clk) disable iff (!rstN)
    match && mode == ccm_pkg::MODE_CMP_SET |=> unitOut)
    else $error("output not high on match");
  a_cmp_low: assert property (@(posedge clk) disable iff (!rstN)
    match && mode == ccm_pkg::MODE_CMP_CLR |=> !unitOut)
    else $error("output not low on match");
  a_cmp_soft: assert property (@(posedge clk) disable iff (!rstN)
    match && mode == ccm_pkg::MODE_CMP_SOFT |=> unitOut == $past(unitOut) && cur.irqStatus[1])
    else $error("soft compare disturbed pin");
  a_special_evt: assert property (@(posedge clk) disable iff (!rstN)
    match && mode == ccm_pkg::MODE_CMP_SPEC |=> timerReset && cur.irqStatus[1])
    else $error("special event missing");
  a_mode_off: assert property (@(posedge clk) disable iff (!rstN)
    mode == ccm_pkg::MODE_OFF |=> !unitOut)
    else $error("unit not reset when off");
  a_rise16: assert property (@(posedge clk) disable iff (!rstN)
    mode == ccm_pkg::MODE_CAP_RISE16 && capEvent |-> cur.prescaleCount == 4'hF)
    else $error("sixteenth edge wrong");
  c_capture: cover property (@(posedge clk) disable iff (!rstN) capEvent);
  c_special: cover property (@(posedge clk) disable iff (!rstN) cur.timerReset);
  a_rise4: assert property (@(posedge clk) disable iff (!rstN)
    mode == ccm_pkg::MODE_CAP_RISE4 && capEvent |-> cur.prescaleCount[1:0] == 2'h3)
    else $error("fourth edge wrong");
  a_capture_mode: assert property (@(posedge clk) disable iff (!rstN)
    capEvent |-> capMode)
    else $error("capture outside capture mode");
  a_prescale_keep: assert property (@(posedge clk) disable iff (!rstN)
    capMode && !pinRise |=> cur.prescaleCount == $past(cur.prescaleCount))
    else $error("prescaler count disturbed");
  a_conv_gate: assert property (@(posedge clk) disable iff (!rstN)
    conversionStart |-> timerReset)
    else $error("conversion start without trigger");
  a_irq_level: assert property (@(posedge clk) disable iff (!rstN)
    irq == |(cur.irqStatus & cur.irqEnable))
    else $error("interrupt level wrong");
  c_irq: cover property (@(posedge clk) disable iff (!rstN) irq);
  c_rise16: cover property (@(posedge clk) disable iff (!rstN)
    mode == ccm_pkg::MODE_CAP_RISE16 && capEvent);
  c_out_high: cover property (@(posedge clk) disable iff (!rstN) $rose(unitOut));
endmodule : capture_compare_mode_control

// ===== design/edge_sync.sv
`timescale 1ns/1ns
// synchronises a level and reports rising and falling edges
module edge_sync (
  input  wire logic clk,
  input  wire logic rstN,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic [2:0] fill;
  } state_t;

  state_t cur;
  state_t next_cur;

  // two-stage synchroniser, then one stage of history
  always_comb begin
    next_cur      = cur;
    next_cur.meta = level;
    next_cur.sync = cur.meta;
    next_cur.prev = cur.sync;
    next_cur.fill = {cur.fill[1:0], 1'b1};
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // edges from consecutive synchronised samples
  // masked until history holds real pin samples, so reset makes no false edge
  assign rise = cur.fill[2] & cur.sync & ~cur.prev;
  assign fall = cur.fill[2] & ~cur.sync & cur.prev;
endmodule : edge_sync

// ===== include/ccm_pkg.sv
package ccm_pkg;
  // register word offsets (byte addresses, 32-bit words)
  localparam logic [7:0] CONTROL_IDX    = 8'h17;                // control word index
  localparam logic [9:0] ADDR_CONTROL   = {CONTROL_IDX, 2'b00};
  localparam logic [9:0] ADDR_CAPTURE   = 10'h080;
  localparam logic [9:0] ADDR_COMPARE   = 10'h084;
  localparam logic [9:0] ADDR_DUTY      = 10'h088;
  localparam logic [9:0] ADDR_IRQ_STAT  = 10'h08C;
  localparam logic [9:0] ADDR_IRQ_EN    = 10'h090;
  localparam logic [9:0] ADDR_IRQ_CLR   = 10'h094;
  localparam logic [9:0] ADDR_ADC_EN    = 10'h098;
  // control register layout
  localparam int        CTRL_WIDTH      = 6;                    // bits 7..6 not stored
  localparam int        MODE_LSB        = 0;
  localparam int        DUTY_LSB_POS    = 4;
  localparam logic [5:0] CTRL_RESET     = 6'h00;
  // mode codes
  localparam logic [3:0] MODE_OFF       = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL  = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE  = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET   = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR   = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT  = 4'hA;
  localparam logic [3:0] MODE_CMP_SPEC  = 4'hB;
  // prescaler counts
  localparam logic [3:0] PRESCALE_4     = 4'h3;
  localparam logic [3:0] PRESCALE_16    = 4'hF;
  // interrupt bits
  localparam int        IRQ_BITS        = 2;
  localparam int        IRQ_CAPTURE     = 0;
  localparam int        IRQ_COMPARE     = 1;
endpackage : ccm_pkg

// ===== testbench/capture_compare_mode_control_tb.sv
`timescale 1ns/1ns
module capture_compare_mode_control_tb;
  `define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t mismatch %h vs %h", $time, (a), (b)); end end
  localparam logic [9:0] CTL = ccm_pkg::ADDR_CONTROL;
  localparam logic [9:0] STA = ccm_pkg::ADDR_IRQ_STAT;
  localparam logic [9:0] CLR = ccm_pkg::ADDR_IRQ_CLR;
  logic        clk, resetn, cyc, stb, we, ack, tgl, uOut, tRst, cStart, pMode, irq, pinLvl;
  logic [9:0]  adr, duty;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rv;
  logic [15:0] tmr, cv;
  logic [1:0]  lag;
  int          bad_count, n_tests, nRst, nConv, i, j;
  logic [3:0]  cm [6] = '{4'h8, 4'hA, 4'hB, 4'h9, 4'h8, 4'h0};
  logic        co [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  capture_compare_mode_control uut (
    .clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .freeRunningTimer(tmr), .unitPin(pinLvl), .unitOut(uOut), .timerReset(tRst),
    .conversionStart(cStart), .pwmDuty(duty), .pwmMode(pMode), .irq(irq));
  pin_source model (.clk(clk), .toggleReq(tgl), .lag(lag), .unitPin(pinLvl));
  // clock source
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // one classic bus cycle, read data left in rv
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int k;
    k = 0;
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    @(posedge clk);
    while (ack !== 1'b1 && k < 40) begin
      @(posedge clk);
      k++;
    end
    rv = rdat;
    {cyc, stb} <= 2'b00;
    if (k == 40) begin
      $display("[ERR] %0t bus timeout", $time);
      bad_count++;
      results();
    end else begin
      repeat (2) @(posedge clk);
    end
  endtask : wb
  task automatic pin();
    lag <= 2'($urandom_range(3));
    tgl <= 1'b1;
    @(posedge clk);
    tgl <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : pin
  // falling edge when f is high, rising otherwise
  task automatic ev(input logic f);
    if (pinLvl !== f) pin();
    pin();
  endtask : ev
  // hang guard
  initial begin
    #200000;
    bad_count++;
    results();
  end
  // main sequence
  initial begin
    {cyc, stb, we, adr, wdat, tgl, lag, tmr} = '0;
    sel = 4'hF;
    resetn = 1'b0;
    bad_count = 0;
    n_tests = 0;
    nRst = 0;
    nConv = 0;
    rv = $urandom(72);
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    wb(0, CTL, 32'h0);
    `CHK(rv, 32'h0)
    wb(1, ccm_pkg::ADDR_DUTY, 32'hA5);
    wb(1, CTL, 32'hFF);
    wb(0, CTL, 32'h0);
    `CHK(rv, 32'h3F)
    `CHK({pMode, duty}, 11'h697)
    wb(1, 10'h3FC, 32'hFFFFFFFF);
    wb(0, 10'h3FC, 32'h0);
    `CHK(rv, 32'h0)
    // every capture code with a random timer value
    for (i = 4; i < 8; i++) begin
      wb(1, CTL, 32'h0);
      wb(1, CTL, 32'(i));
      wb(1, CLR, 32'h3);
      cv = 16'($urandom);
      tmr <= ~cv;
      for (j = 1; j < (i == 6 ? 4 : i == 7 ? 16 : 1); j++) ev(i == 4);
      wb(0, STA, 32'h0);
      `CHK(rv[0], 1'b0)
      tmr <= cv;
      ev(i == 4);
      wb(0, ccm_pkg::ADDR_CAPTURE, 32'h0);
      `CHK(rv[15:0], cv)
      wb(0, STA, 32'h0);
      `CHK(rv[0], 1'b1)
    end
    // second capture before the value is read
    wb(1, CTL, 32'h5);
    tmr <= 16'h1234;
    ev(1'b0);
    tmr <= 16'hBEEF;
    ev(1'b0);
    wb(0, ccm_pkg::ADDR_CAPTURE, 32'h0);
    `CHK(rv[15:0], 16'hBEEF)
    // flag masked, then enabled, then cleared
    `CHK(irq, 1'b0)
    wb(1, ccm_pkg::ADDR_IRQ_EN, 32'h1);
    `CHK(irq, 1'b1)
    wb(1, CLR, 32'h1);
    `CHK(irq, 1'b0)
    // prescaler cleared when off, kept over a direct switch
    for (i = 0; i < 2; i++) begin
      wb(1, CTL, 32'h0);
      wb(1, CTL, 32'h6);
      wb(1, CLR, 32'h1);
      ev(1'b0);
      ev(1'b0);
    end
    wb(0, STA, 32'h0);
    `CHK(rv[0], 1'b0)
    wb(1, CTL, 32'h7);
    wb(1, CTL, 32'h6);
    wb(1, CLR, 32'h1);
    ev(1'b0);
    ev(1'b0);
    wb(0, STA, 32'h0);
    `CHK(rv[0], 1'b1)
    // compare codes then off mode, one single-cycle match each
    wb(1, ccm_pkg::ADDR_ADC_EN, 32'h1);
    for (i = 0; i < 6; i++) begin
      cv = 16'($urandom);
      tmr <= cv + 16'h1;
      wb(1, ccm_pkg::ADDR_COMPARE, 32'(cv));
      wb(1, CTL, 32'(cm[i]));
      wb(1, CLR, 32'h3);
      nRst = 0;
      nConv = 0;
      tmr <= cv;
      @(posedge clk);
      tmr <= cv + 16'h1;
      // counts special event pulses
      repeat (3) begin
        @(posedge clk);
        nRst += int'(tRst === 1'b1);
        nConv += int'(cStart === 1'b1);
      end
      `CHK(uOut, co[i])
      wb(0, STA, 32'h0);
      `CHK(rv[1], cm[i] != 4'h0)
      `CHK(nRst, int'(cm[i] == 4'hB))
      `CHK(nConv, int'(cm[i] == 4'hB))
    end
    results();
  end
endmodule : capture_compare_mode_control_tb

// ===== testbench/pin_source.sv
`timescale 1ns/1ns
// far side of the capture pin: one level change per request, after a lag
module pin_source (
  input  wire logic       clk,
  input  wire logic       toggleReq,
  input  wire logic [1:0] lag,
  output logic            unitPin
);
  logic [1:0] waitCnt = 2'h0;
  logic       pending = 1'b0;
  logic       level   = 1'b1;  // pin idles high
  assign unitPin = level;
  always @(posedge clk) begin
    if (toggleReq) begin
      pending <= 1'b1;
      waitCnt <= lag;
    end else if (pending && waitCnt != 2'h0) begin
      waitCnt <= waitCnt - 2'h1;
    end else if (pending) begin
      pending <= 1'b0;
      level   <= ~level;
    end
  end
endmodule : pin_source
